/* dma_rx_pkg.sv */
package dma_rx_pkg;
	// Register offsets.
	localparam logic [11:0] OFS_FIFO_THRESHOLD = 12'h04c;
	localparam logic [11:0] OFS_BURST_MODE = 12'h080;
	localparam logic [11:0] OFS_POLL_DEMAND = 12'h084;
	localparam logic [11:0] OFS_DESC_BASE = 12'h088;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h08c;
	localparam logic [11:0] OFS_IRQ_ENABLE = 12'h090;
	localparam logic [11:0] OFS_CUR_DESC = 12'h094;
	localparam logic [11:0] OFS_CUR_BUF = 12'h098;
	localparam logic [11:0] OFS_CLOCK_PHASE = 12'h800;
	// Reset values.
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// Field positions.
	localparam int unsigned RECEIVE_WATERMARK_LSB = 16;
	localparam int unsigned RECEIVE_WATERMARK_MSB = 27;
	localparam int unsigned BMOD_FIXED_BURST = 1;
	localparam int unsigned BMOD_ENABLE = 7;
	localparam int unsigned ST_TX_DONE = 0;
	localparam int unsigned ST_RX_DONE = 1;
	localparam int unsigned ST_BUS_ERR = 2;
	localparam int unsigned ST_DESC_UNAVAIL = 4;
	localparam int unsigned ST_NORMAL_SUM = 8;
	localparam int unsigned ST_ABNORMAL_SUM = 9;
	localparam int unsigned DESC_OWN = 31;
	localparam int unsigned DESC_END_OF_RING = 5;
	localparam int unsigned DESC_CHAINED = 4;
	localparam int unsigned DESC_LAST = 2;
	localparam int unsigned DESC_NO_IRQ = 1;
	localparam int unsigned DESC_SIZE_MSB = 12;
	// Counts.
	localparam logic [2:0] DESC_WORDS = 3'h4;
	localparam logic [2:0] BURST_BEATS = 3'h4;
	localparam logic [12:0] BURST_BYTES = 13'h0010;
	localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
	// AHB encodings.
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HBURST_SINGLE = 3'h0;
	localparam logic [2:0] HBURST_INCR4 = 3'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [2:0] hburst;
		logic [31:0] haddr;
		logic [31:0] hwdata;
	} ahb_req_t;

	typedef enum {
		ENG_IDLE, ENG_DESC_RD, ENG_CHECK, ENG_SUSPEND, ENG_WAIT_CMD,
		ENG_WAIT_REQ, ENG_DATA_WR, ENG_OWN_WR, ENG_HALT
	} engine_state_t;
endpackage : dma_rx_pkg

/* descriptor_dma_receive.sv */
`timescale 1ns/10ps
// Contract
// - unowned descriptor suspends engine, flags unavailable when enabled
// - poll-demand write resumes suspended engine
// - data moves only after clean command-done
// - each movement waits for fifo request
// - bursts of four, leftover words as singles
// - fifo words written into descriptor buffer
// - continue with next descriptor until last
// - completion sets receive flag when enabled
// - ownership cleared by write to word zero
// - read-write clock phase register at 0x800
// - each cause has status and enable bit
// - normal summary bit 8, abnormal bit 9
// - writing one clears status bit
// - summary clears when its causes clear
// - interrupt drops only with both summaries clear
// - repeated events do not queue
// - status bit 1 means data reached buffer
// - concurrent events give one interrupt
// - read-only current descriptor and buffer pointers
// - chained flag takes word three as next
// - end-of-ring flag returns to list base (ignored when the chained flag is also set: word three wins)
// - no-irq flag suppresses completion flag
module descriptor_dma_receive (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [11:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	output dma_rx_pkg::ahb_req_t o_ahb,
	input wire logic i_hready,
	input wire logic i_hresp,
	input wire logic [31:0] i_hrdata,
	input wire logic i_command_done_flag,
	input wire logic i_command_error,
	input wire logic i_fifo_transfer_request,
	input wire logic [31:0] i_fifo_rdata,
	output logic o_fifo_pop,
	output logic [11:0] o_receive_watermark,
	output logic [31:0] o_clock_phase_select,
	output logic o_irq
);
	dma_rx_pkg::engine_state_t state_reg, state_next;
	logic [31:0] fifo_threshold_config_reg, burst_mode_config_reg;
	logic [31:0] descriptor_list_base_reg, clock_phase_select_reg;
	logic [9:0] status_reg, enable_reg, status_next;
	logic [31:0] cur_desc_reg, cur_buf_reg, next_desc;
	logic [12:0] offset_reg, remaining;
	logic [31:0] desc_reg [4];
	logic [2:0] issued_reg, done_reg, beats_reg, beats_next;
	logic burst_reg, dvalid_reg, cmd_seen_reg, data_written_reg;
	logic [1:0] didx_reg;
	logic [31:0] job_addr;
	logic in_job, job_go, job_done, bus_err, poll_wr, engine_on, fixed_burst;
	logic ev_rx, ev_du, ev_fbe, normal_sum, abnormal_sum, irq_reg;
	dma_rx_pkg::ahb_req_t ahb_reg;

	assign engine_on = burst_mode_config_reg[dma_rx_pkg::BMOD_ENABLE];
	assign fixed_burst = burst_mode_config_reg[dma_rx_pkg::BMOD_FIXED_BURST];
	assign poll_wr = i_reg_wr && (i_reg_addr == dma_rx_pkg::OFS_POLL_DEMAND);
	assign remaining = desc_reg[1][dma_rx_pkg::DESC_SIZE_MSB:0] - offset_reg;
	assign in_job = (state_reg == dma_rx_pkg::ENG_DESC_RD) ||
		(state_reg == dma_rx_pkg::ENG_DATA_WR) ||
		(state_reg == dma_rx_pkg::ENG_OWN_WR);
	// Must not depend on job_go: job_go comes from state_next, which reads
	// job_done, so that term closes a combinational loop out of OWN_WR.
	assign job_done = in_job && (done_reg == beats_reg);
	assign bus_err = dvalid_reg && i_hready && i_hresp;
	assign o_ahb = ahb_reg;
	assign o_receive_watermark = fifo_threshold_config_reg[
		dma_rx_pkg::RECEIVE_WATERMARK_MSB:dma_rx_pkg::RECEIVE_WATERMARK_LSB];
	assign o_clock_phase_select = clock_phase_select_reg;
	assign o_irq = irq_reg;

	// Chained lists jump through word three, rings wrap to the base.
	always_comb begin
		if (desc_reg[0][dma_rx_pkg::DESC_CHAINED])
			next_desc = desc_reg[3];
		else if (desc_reg[0][dma_rx_pkg::DESC_END_OF_RING])
			next_desc = descriptor_list_base_reg;
		else
			next_desc = cur_desc_reg + dma_rx_pkg::DESC_STRIDE;
	end

	always_comb begin
		case (state_reg)
		dma_rx_pkg::ENG_DESC_RD: job_addr = cur_desc_reg;
		dma_rx_pkg::ENG_DATA_WR: job_addr = job_addr_buf();
		default: job_addr = cur_desc_reg;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
		dma_rx_pkg::ENG_IDLE: begin
			if (engine_on)
				state_next = dma_rx_pkg::ENG_DESC_RD;
		end
		dma_rx_pkg::ENG_DESC_RD: begin
			if (bus_err)
				state_next = dma_rx_pkg::ENG_HALT;
			else if (job_done)
				state_next = dma_rx_pkg::ENG_CHECK;
		end
		dma_rx_pkg::ENG_CHECK: begin
			if (!desc_reg[0][dma_rx_pkg::DESC_OWN])
				state_next = dma_rx_pkg::ENG_SUSPEND;
			else
				state_next = dma_rx_pkg::ENG_WAIT_CMD;
		end
		dma_rx_pkg::ENG_SUSPEND: begin
			if (!engine_on)
				state_next = dma_rx_pkg::ENG_IDLE;
			else if (poll_wr)
				state_next = dma_rx_pkg::ENG_DESC_RD;
		end
		dma_rx_pkg::ENG_WAIT_CMD: begin
			if (!engine_on)
				state_next = dma_rx_pkg::ENG_IDLE;
			else if (cmd_seen_reg)
				state_next = dma_rx_pkg::ENG_WAIT_REQ;
		end
		dma_rx_pkg::ENG_WAIT_REQ: begin
			if (remaining == 13'h0000)
				state_next = dma_rx_pkg::ENG_OWN_WR;
			else if (i_fifo_transfer_request)
				state_next = dma_rx_pkg::ENG_DATA_WR;
		end
		dma_rx_pkg::ENG_DATA_WR: begin
			if (bus_err)
				state_next = dma_rx_pkg::ENG_HALT;
			else if (job_done)
				state_next = dma_rx_pkg::ENG_WAIT_REQ;
		end
		dma_rx_pkg::ENG_OWN_WR: begin
			if (bus_err)
				state_next = dma_rx_pkg::ENG_HALT;
			else if (job_done)
				state_next = dma_rx_pkg::ENG_DESC_RD;
		end
		dma_rx_pkg::ENG_HALT: begin
			if (!engine_on)
				state_next = dma_rx_pkg::ENG_IDLE;
		end
		default: state_next = dma_rx_pkg::ENG_IDLE;
		endcase
	end

	assign job_go = (state_next != state_reg) &&
		((state_next == dma_rx_pkg::ENG_DESC_RD) ||
		(state_next == dma_rx_pkg::ENG_DATA_WR) ||
		(state_next == dma_rx_pkg::ENG_OWN_WR));

	// Full bursts only while a whole burst is left; the tail goes word by word.
	always_comb begin
		if (state_next == dma_rx_pkg::ENG_DESC_RD)
			beats_next = dma_rx_pkg::DESC_WORDS;
		else if ((state_next == dma_rx_pkg::ENG_DATA_WR) && fixed_burst &&
			(remaining >= dma_rx_pkg::BURST_BYTES))
			beats_next = dma_rx_pkg::BURST_BEATS;
		else
			beats_next = 3'h1;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			state_reg <= dma_rx_pkg::ENG_IDLE;
		else
			state_reg <= state_next;
	end

	// AHB master. Address of beat n overlaps the data phase of beat n-1.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ahb_reg <= '0;
			issued_reg <= 3'h0;
			done_reg <= 3'h0;
			beats_reg <= 3'h0;
			burst_reg <= 1'b0;
			dvalid_reg <= 1'b0;
			didx_reg <= 2'h0;
		end else if (job_go) begin
			issued_reg <= 3'h0;
			done_reg <= 3'h0;
			beats_reg <= beats_next;
			burst_reg <= (beats_next == dma_rx_pkg::BURST_BEATS) &&
				(state_next == dma_rx_pkg::ENG_DATA_WR);
		end else if (i_hready) begin
			dvalid_reg <= ahb_reg.htrans != dma_rx_pkg::HTRANS_IDLE;
			didx_reg <= issued_reg[1:0] - 2'h1;
			if (dvalid_reg)
				done_reg <= done_reg + 3'h1;
			if (ahb_reg.htrans != dma_rx_pkg::HTRANS_IDLE) begin
				if (state_reg == dma_rx_pkg::ENG_DATA_WR)
					ahb_reg.hwdata <= i_fifo_rdata;
				else
					ahb_reg.hwdata <= desc_reg[0] &
						~(32'h1 << dma_rx_pkg::DESC_OWN);
			end
			if (in_job && (issued_reg < beats_reg) && !bus_err) begin
				ahb_reg.htrans <= (issued_reg == 3'h0 || !burst_reg) ?
					dma_rx_pkg::HTRANS_NONSEQ : dma_rx_pkg::HTRANS_SEQ;
				ahb_reg.hburst <= burst_reg ? dma_rx_pkg::HBURST_INCR4 :
					dma_rx_pkg::HBURST_SINGLE;
				ahb_reg.hsize <= dma_rx_pkg::HSIZE_WORD;
				ahb_reg.hwrite <= state_reg != dma_rx_pkg::ENG_DESC_RD;
				ahb_reg.haddr <= job_addr + {27'h0, issued_reg, 2'h0};
				issued_reg <= issued_reg + 3'h1;
			end else begin
				ahb_reg.htrans <= dma_rx_pkg::HTRANS_IDLE;
			end
		end
	end

	// A word leaves the fifo as its address phase is accepted.
	assign o_fifo_pop = i_hready && (state_reg == dma_rx_pkg::ENG_DATA_WR) &&
		(ahb_reg.htrans != dma_rx_pkg::HTRANS_IDLE) && !job_go;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int i = 0; i < 4; i++)
				desc_reg[i] <= dma_rx_pkg::RST_WORD;
		end else if (dvalid_reg && i_hready && !i_hresp &&
			(state_reg == dma_rx_pkg::ENG_DESC_RD)) begin
			desc_reg[didx_reg] <= i_hrdata;
		end
	end

	// Progress pointers.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cur_desc_reg <= dma_rx_pkg::RST_WORD;
			cur_buf_reg <= dma_rx_pkg::RST_WORD;
			offset_reg <= 13'h0000;
		end else begin
			if (state_reg == dma_rx_pkg::ENG_IDLE)
				cur_desc_reg <= descriptor_list_base_reg;
			else if ((state_reg == dma_rx_pkg::ENG_OWN_WR) && job_done)
				cur_desc_reg <= next_desc;
			if (state_reg == dma_rx_pkg::ENG_CHECK) begin
				cur_buf_reg <= desc_reg[2];
				offset_reg <= 13'h0000;
			end else if ((state_reg == dma_rx_pkg::ENG_DATA_WR) && job_done) begin
				offset_reg <= offset_reg + {8'h0, beats_reg, 2'h0};
			end
		end
	end

	// A command-done seen early is remembered until the data's last descriptor.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cmd_seen_reg <= 1'b0;
			data_written_reg <= 1'b0;
		end else begin
			if (i_command_done_flag && !i_command_error)
				cmd_seen_reg <= 1'b1;
			else if ((state_reg == dma_rx_pkg::ENG_OWN_WR) && job_done &&
				desc_reg[0][dma_rx_pkg::DESC_LAST])
				cmd_seen_reg <= 1'b0;
			if ((state_reg == dma_rx_pkg::ENG_DATA_WR) && job_done)
				data_written_reg <= 1'b1;
			else if ((state_reg == dma_rx_pkg::ENG_OWN_WR) && job_done &&
				desc_reg[0][dma_rx_pkg::DESC_LAST])
				data_written_reg <= 1'b0;
		end
	end

	// Causes are recorded only when enabled, so a summary is a plain OR.
	assign ev_rx = (state_reg == dma_rx_pkg::ENG_OWN_WR) && job_done &&
		desc_reg[0][dma_rx_pkg::DESC_LAST] && data_written_reg &&
		!desc_reg[0][dma_rx_pkg::DESC_NO_IRQ] &&
		enable_reg[dma_rx_pkg::ST_RX_DONE];
	assign ev_du = (state_reg == dma_rx_pkg::ENG_CHECK) &&
		!desc_reg[0][dma_rx_pkg::DESC_OWN] &&
		enable_reg[dma_rx_pkg::ST_DESC_UNAVAIL];
	assign ev_fbe = bus_err && enable_reg[dma_rx_pkg::ST_BUS_ERR];

	always_comb begin
		status_next = status_reg;
		if (i_reg_wr && (i_reg_addr == dma_rx_pkg::OFS_IRQ_STATUS))
			status_next = status_next & ~i_reg_wdata[9:0];
		// Setting after clearing lets a same-cycle event win; a set bit stays.
		status_next[dma_rx_pkg::ST_RX_DONE] =
			status_next[dma_rx_pkg::ST_RX_DONE] | ev_rx;
		status_next[dma_rx_pkg::ST_DESC_UNAVAIL] =
			status_next[dma_rx_pkg::ST_DESC_UNAVAIL] | ev_du;
		status_next[dma_rx_pkg::ST_BUS_ERR] =
			status_next[dma_rx_pkg::ST_BUS_ERR] | ev_fbe;
		status_next[dma_rx_pkg::ST_TX_DONE] = 1'b0;
		status_next[3] = 1'b0;
		status_next[7:5] = 3'h0;
		status_next[dma_rx_pkg::ST_NORMAL_SUM] = 1'b0;
		status_next[dma_rx_pkg::ST_ABNORMAL_SUM] = 1'b0;
	end

	assign normal_sum = |status_reg[1:0];
	assign abnormal_sum = status_reg[dma_rx_pkg::ST_BUS_ERR] |
		status_reg[dma_rx_pkg::ST_DESC_UNAVAIL];

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			status_reg <= 10'h000;
			irq_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq_reg <= normal_sum | abnormal_sum;
		end
	end

	// Software registers.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			fifo_threshold_config_reg <= dma_rx_pkg::RST_WORD;
			burst_mode_config_reg <= dma_rx_pkg::RST_WORD;
			descriptor_list_base_reg <= dma_rx_pkg::RST_WORD;
			enable_reg <= 10'h000;
			clock_phase_select_reg <= dma_rx_pkg::RST_WORD;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
			dma_rx_pkg::OFS_FIFO_THRESHOLD: fifo_threshold_config_reg <= i_reg_wdata;
			dma_rx_pkg::OFS_BURST_MODE: burst_mode_config_reg <= i_reg_wdata;
			dma_rx_pkg::OFS_DESC_BASE: descriptor_list_base_reg <= i_reg_wdata;
			dma_rx_pkg::OFS_IRQ_ENABLE: enable_reg <= i_reg_wdata[9:0];
			dma_rx_pkg::OFS_CLOCK_PHASE: clock_phase_select_reg <= i_reg_wdata;
			default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_reg_rdata <= dma_rx_pkg::RST_WORD;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
			dma_rx_pkg::OFS_FIFO_THRESHOLD: o_reg_rdata <= fifo_threshold_config_reg;
			dma_rx_pkg::OFS_BURST_MODE: o_reg_rdata <= burst_mode_config_reg;
			dma_rx_pkg::OFS_DESC_BASE: o_reg_rdata <= descriptor_list_base_reg;
			dma_rx_pkg::OFS_IRQ_STATUS: o_reg_rdata <= {22'h0, abnormal_sum,
				normal_sum, status_reg[7:0]};
			dma_rx_pkg::OFS_IRQ_ENABLE: o_reg_rdata <= {22'h0, enable_reg};
			dma_rx_pkg::OFS_CUR_DESC: o_reg_rdata <= cur_desc_reg;
			dma_rx_pkg::OFS_CUR_BUF: o_reg_rdata <= job_addr_buf();
			dma_rx_pkg::OFS_CLOCK_PHASE: o_reg_rdata <= clock_phase_select_reg;
			default: o_reg_rdata <= dma_rx_pkg::RST_WORD;
			endcase
		end else begin
			o_reg_rdata <= dma_rx_pkg::RST_WORD;
		end
	end

	function automatic logic [31:0] job_addr_buf();
		return cur_buf_reg + {19'h0, offset_reg};
	endfunction : job_addr_buf

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_unowned;
		state_reg == dma_rx_pkg::ENG_CHECK && !desc_reg[0][dma_rx_pkg::DESC_OWN];
	endsequence
	sequence s_suspended_poll;
		state_reg == dma_rx_pkg::ENG_SUSPEND && engine_on && poll_wr;
	endsequence

	a_suspend_on_unowned: assert property (s_unowned |=>
		state_reg == dma_rx_pkg::ENG_SUSPEND)
		else $error("unowned descriptor did not suspend");
	a_unavail_flag_set: assert property (s_unowned ##0
		enable_reg[dma_rx_pkg::ST_DESC_UNAVAIL] |=> abnormal_sum)
		else $error("unavailable flag not raised");
	a_poll_release: assert property (s_suspended_poll |=>
		state_reg == dma_rx_pkg::ENG_DESC_RD ##1 ahb_reg.htrans ==
		dma_rx_pkg::HTRANS_NONSEQ || !$past(i_hready))
		else $error("poll demand did not refetch");
	a_data_after_cmd: assert property (state_reg ==
		dma_rx_pkg::ENG_DATA_WR |-> cmd_seen_reg)
		else $error("data moved before command done");
	a_data_needs_request: assert property ((state_reg ==
		dma_rx_pkg::ENG_WAIT_REQ && !i_fifo_transfer_request) |=>
		state_reg != dma_rx_pkg::ENG_DATA_WR)
		else $error("data moved without request");
	a_tail_single: assert property ((job_go && state_next ==
		dma_rx_pkg::ENG_DATA_WR && remaining < dma_rx_pkg::BURST_BYTES) |=>
		!burst_reg && beats_reg == 3'h1)
		else $error("tail not moved as single");
	a_own_cleared: assert property ((state_reg ==
		dma_rx_pkg::ENG_OWN_WR && dvalid_reg) |-> ahb_reg.hwrite &&
		!ahb_reg.hwdata[dma_rx_pkg::DESC_OWN] && $past(ahb_reg.haddr, 1) ==
		cur_desc_reg || !$past(i_hready))
		else $error("ownership write wrong");
	a_rx_flag_set: assert property (ev_rx |=>
		status_reg[dma_rx_pkg::ST_RX_DONE] ##1 o_irq)
		else $error("receive flag or interrupt missing");
	a_no_irq_desc: assert property ((job_done && desc_reg[0][
		dma_rx_pkg::DESC_NO_IRQ] && !status_reg[dma_rx_pkg::ST_RX_DONE]) |=>
		!status_reg[dma_rx_pkg::ST_RX_DONE])
		else $error("suppressed completion flagged");
	a_w1c_clear: assert property ((i_reg_wr && i_reg_addr ==
		dma_rx_pkg::OFS_IRQ_STATUS && i_reg_wdata[1] && !ev_rx) |=>
		!status_reg[dma_rx_pkg::ST_RX_DONE])
		else $error("write one did not clear");
	a_irq_drop: assert property ($fell(o_irq) |->
		!$past(normal_sum) && !$past(abnormal_sum))
		else $error("interrupt dropped with summary set");
endmodule : descriptor_dma_receive

/* host_side_model.sv */
`timescale 1ns/10ps
// Host memory slave and receive fifo source facing the engine.
module host_side_model (
	input wire logic i_clk,
	input wire logic i_slow,
	input wire dma_rx_pkg::ahb_req_t i_ahb,
	input wire logic i_pop,
	input wire logic [31:0] i_seed,
	input wire logic [15:0] i_limit,
	output logic o_hready,
	output logic [31:0] o_hrdata,
	output logic o_request,
	output logic [31:0] o_fifo_rdata
);
	logic [31:0] mem [0:511];
	logic pend = 1'b0;
	logic pend_wr = 1'b0;
	logic [8:0] pend_idx = 9'h000;
	logic [15:0] idx = 16'h0000;
	logic gate = 1'b1;
	initial o_hready = 1'b1;
	always @(posedge i_clk) begin
		if (o_hready && pend && pend_wr)
			mem[pend_idx] <= i_ahb.hwdata;
		if (o_hready) begin
			pend <= i_ahb.htrans[1];
			pend_wr <= i_ahb.hwrite;
			pend_idx <= i_ahb.haddr[10:2];
		end
		// Slow mode stalls the bus and the request at random.
		o_hready <= !i_slow || ($urandom_range(1) == 1);
		gate <= !i_slow || ($urandom_range(1) == 1);
		if (i_pop)
			idx <= idx + 16'h0001;
	end
	// Outside a read data phase the bus shows the inverse, never stale data.
	assign o_hrdata = (pend && !pend_wr) ? mem[pend_idx] : ~mem[pend_idx];
	assign o_request = (idx < i_limit) && gate;
	assign o_fifo_rdata = i_seed + {16'h0000, idx};
endmodule : host_side_model

/* test_descriptor_dma_receive.sv */
`timescale 1ns/10ps
module test_descriptor_dma_receive;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [11:0] i_reg_addr = 12'h000;
	logic [31:0] i_reg_wdata = 32'h0;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic cmd_done = 1'b0;
	logic cmd_err = 1'b0;
	logic slow = 1'b0;
	logic [15:0] limit = 16'h0000;
	logic [31:0] seed = 32'h0;
	logic [31:0] o_reg_rdata;
	logic [31:0] hrdata;
	logic [31:0] fifo_rdata;
	logic [31:0] o_clock_phase_select;
	logic [11:0] o_receive_watermark;
	logic hready;
	logic request;
	logic o_fifo_pop;
	logic o_irq;
	dma_rx_pkg::ahb_req_t o_ahb;
	logic [31:0] rd;
	logic [31:0] v;
	logic [11:0] offs [10] = '{12'h04c, 12'h080, 12'h084, 12'h088,
		12'h08c, 12'h090, 12'h094, 12'h098, 12'h800, 12'h0a0};
	logic [11:0] rw [5] = '{12'h04c, 12'h080, 12'h088, 12'h090, 12'h800};
	int err_total = 0;
	int tests_run = 0;
	int bursts = 0;
	int singles = 0;
	int wr_beats = 0;
	int bad_acc = 0;

	descriptor_dma_receive dut (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
		.o_ahb(o_ahb), .i_hready(hready), .i_hresp(1'b0),
		.i_hrdata(hrdata), .i_command_done_flag(cmd_done),
		.i_command_error(cmd_err), .i_fifo_transfer_request(request),
		.i_fifo_rdata(fifo_rdata), .o_fifo_pop(o_fifo_pop),
		.o_receive_watermark(o_receive_watermark),
		.o_clock_phase_select(o_clock_phase_select), .o_irq(o_irq));

	host_side_model mdl (.i_clk(i_clk), .i_slow(slow), .i_ahb(o_ahb),
		.i_pop(o_fifo_pop), .i_seed(seed), .i_limit(limit),
		.o_hready(hready), .o_hrdata(hrdata), .o_request(request),
		.o_fifo_rdata(fifo_rdata));

	always @(posedge i_clk) begin
		if (i_nrst && hready && o_ahb.htrans[1]) begin
			if (o_ahb.hwrite)
				wr_beats++;
			if (o_ahb.hsize != dma_rx_pkg::HSIZE_WORD || o_ahb.haddr[1:0] != 2'h0)
				bad_acc++;
			if (o_ahb.hwrite && o_ahb.htrans == dma_rx_pkg::HTRANS_NONSEQ) begin
				if (o_ahb.hburst == dma_rx_pkg::HBURST_INCR4)
					bursts++;
				else
					singles++;
			end
		end
	end

	initial begin
		forever #4 i_clk = ~i_clk;
	end

	function automatic logic [31:0] fifo_word(input int i);
		return seed + 32'(i);
	endfunction : fifo_word

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [11:0] a);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		#1;
		rd = o_reg_rdata;
	endtask : reg_rd

	task automatic pulse_done(input logic err);
		@(posedge i_clk);
		cmd_done <= 1'b1;
		cmd_err <= err;
		@(posedge i_clk);
		cmd_done <= 1'b0;
		cmd_err <= 1'b0;
	endtask : pulse_done

	task automatic wait_status(input logic [31:0] m);
		int n;
		n = 0;
		rd = 32'h0;
		while ((rd & m) !== m && n < 500) begin
			reg_rd(dma_rx_pkg::OFS_IRQ_STATUS);
			n++;
		end
		if ((rd & m) !== m) begin
			$display("wrong value at %0t: got %h expected %h", $time, rd, m);
			err_total++;
			complete_run();
		end
	endtask : wait_status

	task automatic put_desc(input logic [31:0] a, input logic [31:0] w0,
		input logic [31:0] sz, input logic [31:0] b, input logic [31:0] nx);
		mdl.mem[a[10:2]] = w0;
		mdl.mem[a[10:2] + 1] = sz;
		mdl.mem[a[10:2] + 2] = b;
		mdl.mem[a[10:2] + 3] = nx;
	endtask : put_desc

	task automatic check_buf(input logic [31:0] a, input int n, input int f);
		for (int i = 0; i < n; i++)
			check(mdl.mem[a[10:2] + i], fifo_word(f + i));
	endtask : check_buf

	initial begin
		void'($urandom(32'ha6756630));
		for (int i = 0; i < 512; i++)
			mdl.mem[i] = 32'h0;
		seed = $urandom;
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		foreach (offs[i]) begin
			reg_rd(offs[i]);
			check(rd, dma_rx_pkg::RST_WORD);
		end
		foreach (rw[i]) begin
			v = $urandom;
			if (rw[i] == dma_rx_pkg::OFS_BURST_MODE)
				v[7] = 1'b0;
			reg_wr(rw[i], v);
			reg_rd(rw[i]);
			if (rw[i] == dma_rx_pkg::OFS_IRQ_ENABLE)
				v = {22'h0, v[9:0]};
			check(rd, v);
			if (rw[i] == dma_rx_pkg::OFS_FIFO_THRESHOLD)
				check({20'h0, o_receive_watermark}, {20'h0, v[27:16]});
			if (rw[i] == dma_rx_pkg::OFS_CLOCK_PHASE)
				check(o_clock_phase_select, v);
		end
		reg_wr(dma_rx_pkg::OFS_DESC_BASE, 32'h0000_0100);
		reg_wr(dma_rx_pkg::OFS_CUR_DESC, $urandom);
		reg_wr(dma_rx_pkg::OFS_CUR_BUF, $urandom);
		reg_rd(dma_rx_pkg::OFS_CUR_DESC);
		check(rd, 32'h0000_0100);
		reg_rd(dma_rx_pkg::OFS_CUR_BUF);
		check(rd, 32'h0);
		$display("register test done");

		reg_wr(dma_rx_pkg::OFS_IRQ_ENABLE, 32'h0);
		reg_wr(dma_rx_pkg::OFS_DESC_BASE, 32'h0000_0100);
		put_desc(32'h100, 32'h0, 32'h18, 32'h400, 32'h0);
		reg_wr(dma_rx_pkg::OFS_BURST_MODE, 32'h0000_0082);
		repeat (40) @(posedge i_clk);
		reg_rd(dma_rx_pkg::OFS_IRQ_STATUS);
		check(rd, 32'h0);
		reg_wr(dma_rx_pkg::OFS_IRQ_ENABLE, 32'h0000_0016);
		reg_wr(dma_rx_pkg::OFS_POLL_DEMAND, $urandom);
		wait_status(32'h10);
		check({31'h0, rd[9] | rd[8]}, 32'h1);
		repeat (2) @(posedge i_clk);
		check({31'h0, o_irq}, 32'h1);
		reg_wr(dma_rx_pkg::OFS_IRQ_STATUS, 32'h0);
		reg_rd(dma_rx_pkg::OFS_IRQ_STATUS);
		check(rd & 32'h10, 32'h10);
		reg_wr(dma_rx_pkg::OFS_IRQ_STATUS, 32'h10);
		reg_rd(dma_rx_pkg::OFS_IRQ_STATUS);
		check(rd & 32'h310, 32'h0);
		repeat (2) @(posedge i_clk);
		check({31'h0, o_irq}, 32'h0);
		$display("suspend test done");

		slow <= 1'b1;
		limit <= 16'h0008;
		put_desc(32'h110, 32'h8000_0004, 32'h8, 32'h500, 32'h0);
		put_desc(32'h120, 32'h0, 32'h8, 32'h600, 32'h0);
		put_desc(32'h100, 32'h8000_0000, 32'h18, 32'h400, 32'h0);
		reg_wr(dma_rx_pkg::OFS_POLL_DEMAND, 32'h0);
		repeat (60) @(posedge i_clk);
		check(32'(wr_beats), 32'h0);
		pulse_done(1'b1);
		repeat (40) @(posedge i_clk);
		check(32'(wr_beats), 32'h0);
		pulse_done(1'b0);
		reg_wr(dma_rx_pkg::OFS_FIFO_THRESHOLD, 32'h0004_0000);
		wait_status(32'h12);
		check_buf(32'h400, 6, 0);
		check_buf(32'h500, 2, 6);
		check(mdl.mem[64], 32'h0);
		check(mdl.mem[68], 32'h0000_0004);
		check(32'(bursts), 32'h1);
		check(32'(singles), 32'h6);
		reg_rd(dma_rx_pkg::OFS_CUR_DESC);
		check(rd, 32'h0000_0120);
		check({31'h0, o_irq}, 32'h1);
		reg_wr(dma_rx_pkg::OFS_IRQ_STATUS, 32'h0000_ffff);
		$display("transfer test done");

		put_desc(32'h180, 32'h8000_0026, 32'h4, 32'h700, 32'h0);
		put_desc(32'h120, 32'h8000_0010, 32'h8, 32'h600, 32'h180);
		limit <= 16'h000b;
		pulse_done(1'b0);
		reg_wr(dma_rx_pkg::OFS_POLL_DEMAND, $urandom);
		wait_status(32'h10);
		check(rd & 32'h2, 32'h0);
		check_buf(32'h600, 2, 8);
		check_buf(32'h700, 1, 10);
		check(mdl.mem[96], 32'h0000_0026);
		reg_rd(dma_rx_pkg::OFS_CUR_DESC);
		check(rd, 32'h0000_0100);
		check(32'(bad_acc), 32'h0);
		$display("chain and ring test done");
		complete_run();
	end
endmodule : test_descriptor_dma_receive
